//--- hw/dma4_params.svh
// register offsets, field positions, reset values and target decode of the dma control block
// assumes a 12-bit apb byte address and 16-bit wide channel registers
`ifndef DMA4_PARAMS_SVH
`define DMA4_PARAMS_SVH

// ********************************************************************
// register map: channel n at n*0x20, register index in paddr[4:2]
// ********************************************************************
`define CH_STRIDE_SHIFT 5
`define IDX_SRC_HI 3'h0
`define IDX_SRC_LO 3'h1
`define IDX_DST_HI 3'h2
`define IDX_DST_LO 3'h3
`define IDX_COUNT 3'h4
`define IDX_DIR 3'h5
`define IDX_CTRL 3'h6
`define IDX_TRIG 3'h7
`define OFF_WAIT_CTRL 12'h080

// ********************************************************************
// field positions
// ********************************************************************
`define CTRL_ENABLE 0
`define CTRL_INIT 1
`define CTRL_SW_TRIG 2
`define CTRL_TC 7
`define TRIG_PENDING 7
`define DIR_HALFWORD 14
`define DIR_SRC_HI 7
`define DIR_SRC_LO 6
`define DIR_DST_HI 5
`define DIR_DST_LO 4
`define HI_ADDR_TOP 9

// ********************************************************************
// reset values and target decode
// ********************************************************************
`define WAIT_CTRL_RESET 8'h77
`define TRIG_FIELD_RESET 6'h00
`define TGT_SPACE_BIT_HI 25
`define TGT_SPACE_BIT_LO 24
`define TGT_ONCHIP_SPACE 2'h3
`define TGT_PIO_BIT 23
`define LAST_TRANSFER 16'h0001

`endif

//--- hw/dma4_pkg.sv
// types shared by the dma control block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package dma4_pkg;

  // transfer engine states, one-hot
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_read  = 4'b0010,
    st_gap   = 4'b0100,
    st_write = 4'b1000
  } xfer_state_t;

  // which bus a transfer address belongs to
  typedef enum logic [1:0] {
    tgt_ext = 2'h0,
    tgt_ram = 2'h1,
    tgt_pio = 2'h2
  } target_t;

endpackage : dma4_pkg
`default_nettype wire

//--- hw/fixed_prio_pick.sv
// fixed priority picker: lowest index wins
// assumes a combinational consumer that registers the result
`default_nettype none
module fixed_prio_pick (
  input wire logic [3:0] req,
  output logic any,
  output logic [1:0] idx
);

  // ********************************************************************
  // priority encode
  // ********************************************************************
  // channel 0 is checked last so it overrides the others
  always_comb begin
    any = |req;
    idx = 2'h0;
    if (req[3]) idx = 2'h3;
    if (req[2]) idx = 2'h2;
    if (req[1]) idx = 2'h1;
    if (req[0]) idx = 2'h0;
  end

endmodule : fixed_prio_pick
`default_nettype wire

//--- hw/dma4_ctrl.sv
// four channel dma control: apb registers, request handling, arbitration, transfer engine
// assumes one 100 mhz clock, a memory port that answers with mem_ready,
// and hardware requests that are one-cycle pulses per channel
`include "dma4_params.svh"
`default_nettype none

// Behaviour
// - four channels, each with own address, count, direction and control registers
// - a request for the channel now transferring is dropped, not queued
// - several requests: highest granted, lower ones stay pending for next slot
// - reading control clears the terminal-count flag that was shown
// - count reads initial value after good init, else remaining value
// - enable low halts channel; enable high resumes where it stopped
// - trigger register pending flag reads zero when no accepted request waits
// - odd addresses of halfword transfers have their lowest bit forced to zero
// - dma outranks cpu; cpu waits for busy target until cycle ends
// - external-to-peripheral transfer lets cpu reach internal ram freely
// - external-to-external transfer lets cpu reach ram and peripherals
// - mode 00 increments source; halves update live after each transfer
// - fixed priority channel 0 highest, re-checked every transfer slot
// - terminal count clears enable, sets flag, pulses transfer-end request
// - read cycle, exactly one idle clock, then write cycle
module dma4_ctrl
  import dma4_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] hw_req,
  output logic [25:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_halfword,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ready,
  input wire logic cpu_req,
  input wire logic [25:0] cpu_addr,
  output logic cpu_wait,
  output logic [3:0] transfer_end_irq,
  output logic [7:0] wait_ctrl
);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ********************************************************************
  // helpers
  // ********************************************************************
  // halfword transfers drop the odd bit; byte transfers keep it
  function automatic logic [25:0] eff_addr(input logic [15:0] hi, input logic [15:0] lo,
                                           input logic hw);
    eff_addr = {hi[`HI_ADDR_TOP:0], lo[15:1], lo[0] & ~hw};
  endfunction : eff_addr

  function automatic logic [25:0] step_of(input logic [1:0] mode, input logic hw);
    case (mode)
      2'b00: step_of = hw ? 26'h0000002 : 26'h0000001;
      2'b01: step_of = hw ? 26'h3fffffe : 26'h3ffffff;
      default: step_of = 26'h0000000;
    endcase
  endfunction : step_of

  function automatic target_t target_of(input logic [25:0] a);
    if (a[`TGT_SPACE_BIT_HI:`TGT_SPACE_BIT_LO] != `TGT_ONCHIP_SPACE) target_of = tgt_ext;
    else if (a[`TGT_PIO_BIT]) target_of = tgt_pio;
    else target_of = tgt_ram;
  endfunction : target_of

  // ********************************************************************
  // state declarations
  // ********************************************************************
  logic [15:0] src_hi_q [4], src_hi_d [4];
  logic [15:0] src_lo_q [4], src_lo_d [4];
  logic [15:0] dst_hi_q [4], dst_hi_d [4];
  logic [15:0] dst_lo_q [4], dst_lo_d [4];
  logic [15:0] cnt_init_q [4], cnt_init_d [4];
  logic [15:0] cnt_rem_q [4], cnt_rem_d [4];
  logic [15:0] dir_q [4], dir_d [4];
  logic [5:0] trig_q [4], trig_d [4];
  logic [3:0] en_q, en_d, tc_q, tc_d, pend_q, pend_d, irq_q, irq_d;
  logic [7:0] wait_q, wait_d;
  logic [31:0] rd_q, rd_d;
  logic rdy_q, rdy_d, err_q, err_d;
  xfer_state_t st_q, st_d;
  logic [1:0] act_q, act_d;
  logic [15:0] data_q, data_d, mwd_q, mwd_d;
  logic [25:0] maddr_q, maddr_d;
  logic mrd_q, mrd_d, mwr_q, mwr_d, mhw_q, mhw_d, cwait_q, cwait_d;
  target_t stgt_q, stgt_d, dtgt_q, dtgt_d;
  logic [3:0] cand, start_mask;
  logic pick_any, grant_take, xfer_done;
  logic [1:0] pick_idx;
  logic setup, access, wr_go, rd_go, chan_sel;
  logic [1:0] ch;
  logic [2:0] ridx;

  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign mem_addr = maddr_q;
  assign mem_rd = mrd_q;
  assign mem_wr = mwr_q;
  assign mem_halfword = mhw_q;
  assign mem_wdata = mwd_q;
  assign cpu_wait = cwait_q;
  assign transfer_end_irq = irq_q;
  assign wait_ctrl = wait_q;

  // apb phase decode, shared by read mux and write path
  assign setup = psel & ~penable;
  assign access = psel & penable & rdy_q;
  assign chan_sel = (paddr[11:7] == 5'h00);
  assign ch = paddr[6:`CH_STRIDE_SHIFT];
  assign ridx = paddr[4:2];
  assign wr_go = access & pwrite & ~err_q;
  assign rd_go = access & ~pwrite & ~err_q;

  // ********************************************************************
  // arbitration
  // ********************************************************************
  // disabled or finished channels keep their pending bit but are not served
  assign cand = pend_q & en_q & ~tc_q;

  fixed_prio_pick u_pick (
    .req(cand),
    .any(pick_any),
    .idx(pick_idx)
  );

  // ********************************************************************
  // apb slave: no wait states, read data captured in setup
  // ********************************************************************
  always_comb begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    rdy_d = setup;
    if (setup) begin
      if (chan_sel) begin
        case (ridx)
          `IDX_SRC_HI: rd_d[15:0] = src_hi_q[ch];
          `IDX_SRC_LO: rd_d[15:0] = src_lo_q[ch];
          `IDX_DST_HI: rd_d[15:0] = dst_hi_q[ch];
          `IDX_DST_LO: rd_d[15:0] = dst_lo_q[ch];
          `IDX_COUNT: rd_d[15:0] = cnt_rem_q[ch];
          `IDX_DIR: rd_d[15:0] = dir_q[ch];
          `IDX_CTRL: begin
            rd_d[`CTRL_ENABLE] = en_q[ch];
            rd_d[`CTRL_TC] = tc_q[ch];
          end
          `IDX_TRIG: begin
            rd_d[5:0] = trig_q[ch];
            rd_d[`TRIG_PENDING] = pend_q[ch];
          end
          default: rd_d = 32'h00000000;
        endcase
      end else if (paddr == `OFF_WAIT_CTRL) begin
        rd_d[7:0] = wait_q;
      end else begin
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 32'h00000000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // ********************************************************************
  // transfer engine
  // ********************************************************************
  // the idle state between transfers hands the bus back to the cpu
  always_comb begin
    st_d = st_q;
    act_d = act_q;
    data_d = data_q;
    maddr_d = maddr_q;
    mrd_d = mrd_q;
    mwr_d = mwr_q;
    mhw_d = mhw_q;
    mwd_d = mwd_q;
    stgt_d = stgt_q;
    dtgt_d = dtgt_q;
    grant_take = 1'b0;
    xfer_done = 1'b0;
    case (st_q)
      st_idle: begin
        if (pick_any) begin
          grant_take = 1'b1;
          act_d = pick_idx;
          mhw_d = dir_q[pick_idx][`DIR_HALFWORD];
          maddr_d = eff_addr(src_hi_q[pick_idx], src_lo_q[pick_idx], mhw_d);
          stgt_d = target_of(maddr_d);
          dtgt_d = target_of(eff_addr(dst_hi_q[pick_idx], dst_lo_q[pick_idx], mhw_d));
          mrd_d = 1'b1;
          st_d = st_read;
        end
      end
      st_read: begin
        if (mem_ready) begin
          data_d = mem_rdata;
          mrd_d = 1'b0;
          st_d = st_gap;
        end
      end
      st_gap: begin
        maddr_d = eff_addr(dst_hi_q[act_q], dst_lo_q[act_q], mhw_q);
        mwd_d = data_q;
        mwr_d = 1'b1;
        st_d = st_write;
      end
      st_write: begin
        if (mem_ready) begin
          mwr_d = 1'b0;
          xfer_done = 1'b1;
          st_d = st_idle;
        end
      end
      default: begin
        st_d = st_idle;
        mrd_d = 1'b0;
        mwr_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= st_idle;
      act_q <= 2'h0;
      data_q <= 16'h0000;
      maddr_q <= 26'h0000000;
      mrd_q <= 1'b0;
      mwr_q <= 1'b0;
      mhw_q <= 1'b0;
      mwd_q <= 16'h0000;
      stgt_q <= tgt_ext;
      dtgt_q <= tgt_ext;
    end else begin
      st_q <= st_d;
      act_q <= act_d;
      data_q <= data_d;
      maddr_q <= maddr_d;
      mrd_q <= mrd_d;
      mwr_q <= mwr_d;
      mhw_q <= mhw_d;
      mwd_q <= mwd_d;
      stgt_q <= stgt_d;
      dtgt_q <= dtgt_d;
    end
  end

  sequence s_read_end;
    st_q == st_read && mem_ready;
  endsequence
  sequence s_gap_then_write;
    !mrd_q && !mwr_q ##1 mwr_q;
  endsequence
  property p_one_idle_clock;
    s_read_end |=> s_gap_then_write;
  endproperty
  a_one_idle_clock: assert property (p_one_idle_clock) else $error("gap not one clock");
  property p_lsb_forced;
    mhw_q && (mrd_q || mwr_q) |-> !maddr_q[0];
  endproperty
  a_lsb_forced: assert property (p_lsb_forced) else $error("odd halfword address");
  property p_prio_ch0;
    st_q == st_idle && cand[0] |=> act_q == 2'h0 && st_q == st_read;
  endproperty
  a_prio_ch0: assert property (p_prio_ch0) else $error("channel 0 not granted");

  // ********************************************************************
  // cpu bus arbitration
  // ********************************************************************
  // only targets the running transfer touches make the cpu wait
  always_comb begin
    cwait_d = cpu_req & (st_q != st_idle) &
              ((target_of(cpu_addr) == stgt_q) | (target_of(cpu_addr) == dtgt_q));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cwait_q <= 1'b0;
    else cwait_q <= cwait_d;
  end

  property p_cpu_free_when_idle;
    st_q == st_idle |=> !cwait_q;
  endproperty
  a_cpu_free_when_idle: assert property (p_cpu_free_when_idle) else $error("cpu held idle");
  property p_cpu_ram_free;
    cpu_req && target_of(cpu_addr) == tgt_ram && stgt_q != tgt_ram && dtgt_q != tgt_ram
      |=> !cwait_q;
  endproperty
  a_cpu_ram_free: assert property (p_cpu_ram_free) else $error("cpu ram blocked");

  // ********************************************************************
  // channel registers, requests and terminal count
  // ********************************************************************
  // a request for the running or just-granted channel is dropped
  always_comb begin
    start_mask = 4'h0;
    if (st_q != st_idle) start_mask[act_q] = 1'b1;
    if (grant_take) start_mask[pick_idx] = 1'b1;
  end

  // hardware updates come after software writes so they win
  always_comb begin
    logic [25:0] na;
    logic [3:0] req_in;
    na = 26'h0000000;
    req_in = hw_req;
    src_hi_d = src_hi_q;
    src_lo_d = src_lo_q;
    dst_hi_d = dst_hi_q;
    dst_lo_d = dst_lo_q;
    cnt_init_d = cnt_init_q;
    cnt_rem_d = cnt_rem_q;
    dir_d = dir_q;
    trig_d = trig_q;
    en_d = en_q;
    tc_d = tc_q;
    pend_d = pend_q;
    irq_d = 4'h0;
    wait_d = wait_q;
    if (grant_take) pend_d[pick_idx] = 1'b0;
    if (wr_go && !chan_sel) wait_d = pwdata[7:0];
    if (wr_go && chan_sel) begin
      case (ridx)
        `IDX_SRC_HI: src_hi_d[ch] = pwdata[15:0];
        `IDX_SRC_LO: src_lo_d[ch] = pwdata[15:0];
        `IDX_DST_HI: dst_hi_d[ch] = pwdata[15:0];
        `IDX_DST_LO: dst_lo_d[ch] = pwdata[15:0];
        `IDX_COUNT: begin
          cnt_init_d[ch] = pwdata[15:0];
          cnt_rem_d[ch] = pwdata[15:0];
        end
        `IDX_DIR: dir_d[ch] = pwdata[15:0];
        `IDX_CTRL: begin
          en_d[ch] = pwdata[`CTRL_ENABLE];
          req_in[ch] = hw_req[ch] | pwdata[`CTRL_SW_TRIG];
          if (pwdata[`CTRL_INIT] && !(st_q != st_idle && act_q == ch)) begin
            pend_d[ch] = 1'b0;
            cnt_rem_d[ch] = cnt_init_q[ch];
            tc_d[ch] = 1'b0;
          end
        end
        `IDX_TRIG: trig_d[ch] = pwdata[5:0];
        default: trig_d[ch] = trig_q[ch];
      endcase
    end
    // only the flag value that the read returned is cleared
    if (rd_go && chan_sel && ridx == `IDX_CTRL && rd_q[`CTRL_TC]) tc_d[ch] = 1'b0;
    if (xfer_done) begin
      na = eff_addr(src_hi_q[act_q], src_lo_q[act_q], mhw_q) +
           step_of(dir_q[act_q][`DIR_SRC_HI:`DIR_SRC_LO], mhw_q);
      src_lo_d[act_q] = na[15:0];
      src_hi_d[act_q] = {src_hi_q[act_q][15:10], na[25:16]};
      na = eff_addr(dst_hi_q[act_q], dst_lo_q[act_q], mhw_q) +
           step_of(dir_q[act_q][`DIR_DST_HI:`DIR_DST_LO], mhw_q);
      dst_lo_d[act_q] = na[15:0];
      dst_hi_d[act_q] = {dst_hi_q[act_q][15:10], na[25:16]};
      cnt_rem_d[act_q] = cnt_rem_q[act_q] - 16'h0001;
      if (cnt_rem_q[act_q] == `LAST_TRANSFER) begin
        cnt_rem_d[act_q] = cnt_init_q[act_q];
        en_d[act_q] = 1'b0;
        tc_d[act_q] = 1'b1;
        irq_d[act_q] = 1'b1;
      end
    end
    // accepted only while enabled, unfinished, not pending and not running
    pend_d = pend_d | (req_in & en_q & ~tc_q & ~pend_q & ~start_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        src_hi_q[i] <= 16'h0000;
        src_lo_q[i] <= 16'h0000;
        dst_hi_q[i] <= 16'h0000;
        dst_lo_q[i] <= 16'h0000;
        cnt_init_q[i] <= 16'h0000;
        cnt_rem_q[i] <= 16'h0000;
        dir_q[i] <= 16'h0000;
        trig_q[i] <= `TRIG_FIELD_RESET;
      end
      en_q <= 4'h0;
      tc_q <= 4'h0;
      pend_q <= 4'h0;
      irq_q <= 4'h0;
      wait_q <= `WAIT_CTRL_RESET;
    end else begin
      src_hi_q <= src_hi_d;
      src_lo_q <= src_lo_d;
      dst_hi_q <= dst_hi_d;
      dst_lo_q <= dst_lo_d;
      cnt_init_q <= cnt_init_d;
      cnt_rem_q <= cnt_rem_d;
      dir_q <= dir_d;
      trig_q <= trig_d;
      en_q <= en_d;
      tc_q <= tc_d;
      pend_q <= pend_d;
      irq_q <= irq_d;
      wait_q <= wait_d;
    end
  end

  property p_same_channel_dropped;
    st_q != st_idle && !pend_q[act_q] |=> !pend_q[$past(act_q)];
  endproperty
  a_same_channel_dropped: assert property (p_same_channel_dropped)
    else $error("same channel request queued");
  property p_lower_kept;
    st_q == st_idle && cand[0] && cand[1] |=> pend_q[1] && act_q == 2'h0;
  endproperty
  a_lower_kept: assert property (p_lower_kept) else $error("lower request lost");
  property p_terminal_count;
    xfer_done && cnt_rem_q[act_q] == `LAST_TRANSFER
      |=> tc_q[act_q] && !en_q[act_q] && irq_q[act_q] ##1 irq_q == 4'h0;
  endproperty
  a_terminal_count: assert property (p_terminal_count) else $error("terminal count wrong");
  property p_idle_stays_idle;
    st_q == st_idle && cand == 4'h0 |=> st_q == st_idle && !mrd_q;
  endproperty
  a_idle_stays_idle: assert property (p_idle_stays_idle) else $error("transfer w/o request");
  property p_tc_read_clear;
    rd_go && chan_sel && ridx == `IDX_CTRL && rd_q[`CTRL_TC] && !xfer_done
      |=> !tc_q[$past(ch)];
  endproperty
  a_tc_read_clear: assert property (p_tc_read_clear) else $error("flag not cleared");

endmodule : dma4_ctrl
`default_nettype wire

//--- testbench/dma4_mem_model.sv
// memory-side partner of the dma block: answers strobes after a set stall
// assumes registered strobes from the dma block, all on pclk rising edge
`default_nettype none
module dma4_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [25:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ready,
  input wire logic [3:0] stall
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  logic [15:0] last;
  logic [7:0] idle_q;
  logic [7:0] gap;
  logic [25:0] wa [$];
  logic [15:0] wd [$];

  // data follows the address; a released bus churns so stale data never matches
  assign mem_rdata = mem_rd ? (mem_addr[15:0] ^ 16'h5a5a) : ~last;

  // stall, then one ready pulse; log writes and the idle gap before each
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      mem_ready <= 1'b0;
      idle_q <= 8'h0;
      gap <= 8'h0;
      last <= 16'h0;
    end else begin
      if ((mem_rd || mem_wr) && !mem_ready) begin
        cnt <= cnt + 4'h1;
        mem_ready <= (cnt == stall);
      end else begin
        cnt <= 4'h0;
        mem_ready <= 1'b0;
      end
      if (mem_wr && mem_ready) begin
        wa.push_back(mem_addr);
        wd.push_back(mem_wdata);
      end
      idle_q <= (mem_rd || mem_wr) ? 8'h0 : idle_q + 8'h1;
      if (mem_wr && idle_q != 8'h0) gap <= idle_q;
      last <= mem_rdata;
    end
  end
endmodule : dma4_mem_model
`default_nettype wire

//--- testbench/four_channel_dma_control_tb_top.sv
// bench for the dma control block: apb register tasks and transfer scenarios
// assumes the memory partner model and the register map of dma4_params.svh
`include "dma4_params.svh"
`default_nettype none
module four_channel_dma_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_req = 0;
  logic pready, pslverr, err, mem_rd, mem_wr, mem_halfword, mem_ready, cpu_wait;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] hw_req = 0, irq, irq_seen = 0, stall = 0;
  logic [25:0] mem_addr, cpu_addr = 0;
  logic [15:0] mem_wdata, mem_rdata;
  logic [7:0] wait_ctrl;
  int n_fail = 0, tests_run = 0, cyc = 0;

  dma4_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_req(hw_req), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_halfword(mem_halfword), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ready(mem_ready), .cpu_req(cpu_req),
    .cpu_addr(cpu_addr), .cpu_wait(cpu_wait), .transfer_end_irq(irq),
    .wait_ctrl(wait_ctrl));
  dma4_mem_model m (.pclk(pclk), .presetn(presetn), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ready(mem_ready), .stall(stall));

  always #5 pclk = ~pclk;
  // end-of-transfer pulses last one cycle, so keep a sticky copy
  always @(posedge pclk) irq_seen <= irq_seen | irq;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      complete_run;
    end
  end

  // ********
  // tasks
  // ********
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // setup, access, hold until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [11:0] ra(input logic [1:0] c, input logic [2:0] i);
    return {5'h0, c, i, 2'h0};
  endfunction : ra

  // halfword, both addresses incrementing; reserved bits left zero
  task cfg(input logic [1:0] c, input logic [25:0] s, input logic [25:0] t,
           input logic [15:0] n);
    apb(1, ra(c, `IDX_SRC_HI), {22'h0, s[25:16]});
    apb(1, ra(c, `IDX_SRC_LO), {16'h0, s[15:0]});
    apb(1, ra(c, `IDX_DST_HI), {22'h0, t[25:16]});
    apb(1, ra(c, `IDX_DST_LO), {16'h0, t[15:0]});
    apb(1, ra(c, `IDX_COUNT), {16'h0, n});
    apb(1, ra(c, `IDX_DIR), 32'h4000);
  endtask : cfg

  task pulse(input logic [3:0] v);
    @(posedge pclk);
    hw_req <= v;
    @(posedge pclk);
    hw_req <= 4'h0;
  endtask : pulse

  // let the closing idle cycle land before looking at registers
  task wait_wr(input int n);
    while (m.wa.size() < n) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : wait_wr

  // ********
  // tests
  // ********
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("wait_ctrl out", {24'h0, wait_ctrl}, 32'h77);
    apb(0, `OFF_WAIT_CTRL, 0);
    chk("wait_ctrl reg", rd, 32'h77);
    apb(1, `OFF_WAIT_CTRL, 32'h03);
    // the write lands on the access edge; look one clock later
    @(posedge pclk);
    chk("wait_ctrl new", {24'h0, wait_ctrl}, 32'h03);
    apb(1, ra(3, `IDX_SRC_LO), 32'h0abc);
    apb(0, ra(3, `IDX_SRC_LO), 0);
    chk("ch3 src", rd, 32'h0abc);
    apb(0, 12'h0c0, 0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test registers done");

    cfg(0, 26'h1001, 26'h2003, 16'h2);
    apb(1, ra(0, `IDX_CTRL), 32'h1);
    apb(1, ra(0, `IDX_CTRL), 32'h5);
    wait_wr(1);
    chk("odd dst", {6'h0, m.wa[0]}, 32'h2002);
    chk("odd src", {16'h0, m.wd[0]}, 32'h1000 ^ 32'h5a5a);
    chk("gap", {24'h0, m.gap}, 32'h1);
    apb(0, ra(0, `IDX_COUNT), 0);
    chk("count left", rd, 32'h1);
    apb(1, ra(0, `IDX_CTRL), 32'h5);
    wait_wr(2);
    chk("inc dst", {6'h0, m.wa[1]}, 32'h2004);
    chk("inc src", {16'h0, m.wd[1]}, 32'h1002 ^ 32'h5a5a);
    apb(0, ra(0, `IDX_CTRL), 0);
    chk("tc set", rd & 32'h81, 32'h80);
    chk("irq", {28'h0, irq_seen}, 32'h1);
    repeat (3) apb(0, ra(0, `IDX_CTRL), 0);
    chk("tc clear", rd & 32'h80, 32'h0);
    $display("test single channel done");

    stall <= 4'h5;
    for (int c = 0; c < 3; c++) begin
      cfg(c[1:0], 26'h8000, 26'h4000 + 26'(c) * 26'h100, 16'h4);
      apb(1, ra(c[1:0], `IDX_CTRL), 32'h1);
    end
    cpu_addr <= 26'h10;
    cpu_req <= 1'b1;
    pulse(4'b0111);
    while (mem_rd !== 1'b1) @(posedge pclk);
    chk("halfword", {31'h0, mem_halfword}, 32'h1);
    pulse(4'b0001);
    apb(0, ra(1, `IDX_TRIG), 0);
    chk("pending", rd & 32'h80, 32'h80);
    chk("cpu ext", {31'h0, cpu_wait}, 32'h1);
    cpu_addr <= 26'h3000000;
    repeat (2) @(posedge pclk);
    chk("cpu ram", {31'h0, cpu_wait}, 32'h0);
    cpu_addr <= 26'h3800000;
    repeat (2) @(posedge pclk);
    chk("cpu pio", {31'h0, cpu_wait}, 32'h0);
    cpu_req <= 1'b0;
    wait_wr(5);
    for (int i = 0; i < 3; i++)
      chk("order", {6'h0, m.wa[2 + i]}, 32'h4000 + 32'(i) * 32'h100);
    apb(0, ra(0, `IDX_COUNT), 0);
    chk("same channel drop", rd, 32'h3);
    apb(0, ra(1, `IDX_TRIG), 0);
    chk("no pending", rd & 32'h80, 32'h0);
    $display("test arbitration done");

    apb(1, ra(1, `IDX_CTRL), 0);
    apb(1, ra(1, `IDX_CTRL), 0);
    pulse(4'b0010);
    repeat (20) @(posedge pclk);
    chk("halted", 32'(m.wa.size()), 32'h5);
    apb(1, ra(1, `IDX_CTRL), 32'h1);
    pulse(4'b0010);
    wait_wr(6);
    chk("resume", {6'h0, m.wa[5]}, 32'h4102);
    apb(1, ra(1, `IDX_CTRL), 32'h3);
    apb(0, ra(1, `IDX_COUNT), 0);
    chk("init count", rd, 32'h4);
    $display("test stop and init done");
    complete_run;
  end
endmodule : four_channel_dma_control_tb_top
`default_nettype wire
